// [sfc_band_acc.sv]
// Band accumulator: sums the samples of one contiguous channel run and counts them.
`default_nettype none
module sfc_band_acc
(
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_resetn,
    // Sample stream
    input wire logic i_clear,
    input wire logic i_smp_take,
    input wire logic [sfc_pkg::CHAN_W-1:0] i_smp_chan,
    input wire logic [sfc_pkg::DATA_W-1:0] i_smp_data,
    // Band definition
    input wire logic i_band_en,
    input wire logic [sfc_pkg::CHAN_W-1:0] i_band_lo,
    input wire logic [sfc_pkg::CHAN_W-1:0] i_band_hi,
    // Results
    output logic [sfc_pkg::SUM_W-1:0] o_sum,
    output logic [sfc_pkg::CNT_W-1:0] o_cnt
);
    logic [sfc_pkg::SUM_W-1:0] sum_r;
    logic [sfc_pkg::SUM_W-1:0] sum_nxt;
    logic [sfc_pkg::CNT_W-1:0] cnt_r;
    logic [sfc_pkg::CNT_W-1:0] cnt_nxt;
    logic in_band;

    // A sample counts only when its channel lies inside the enabled run.
    assign in_band = i_band_en && (i_smp_chan >= i_band_lo) && (i_smp_chan <= i_band_hi);

    // Clear wins, since it only comes between events.
    always_comb
    begin
        sum_nxt = sum_r;
        cnt_nxt = cnt_r;
        if (i_clear)
        begin
            sum_nxt = sfc_pkg::SUM_RST;
            cnt_nxt = sfc_pkg::CNT_RST;
        end
        else if (i_smp_take && in_band)
        begin
            sum_nxt = sum_r + sfc_pkg::SUM_W'(i_smp_data);
            cnt_nxt = cnt_r + sfc_pkg::CNT_ONE;
        end
    end

    // Register the running sum and count.
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_resetn)
        begin
            sum_r <= sfc_pkg::SUM_RST;
            cnt_r <= sfc_pkg::CNT_RST;
        end
        else
        begin
            sum_r <= sum_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    assign o_sum = sum_r;
    assign o_cnt = cnt_r;
endmodule
`default_nettype wire

// [sfc_pkg.sv]
// Constants and types shared by the spectral flag comparator files.
`default_nettype none
package sfc_pkg;
    // ****************************************
    // Sizes
    // ****************************************
    localparam int NUM_FLAGS = 8;
    localparam int NUM_BANDS = 8;
    localparam int DATA_W = 16;
    localparam int CHAN_W = 6;
    localparam int MULT_W = 8;
    localparam int BSEL_W = 3;
    localparam int SUM_W = DATA_W + CHAN_W;
    localparam int CNT_W = CHAN_W + 1;
    localparam int PROD_W = MULT_W + SUM_W + CNT_W;
    localparam int DISC_W = 256;

    // ****************************************
    // Constant operand and reset values
    // ****************************************
    localparam logic [SUM_W-1:0] LSB_SUM = 22'h000001;
    localparam logic [CNT_W-1:0] LSB_CNT = 7'h01;
    localparam logic [SUM_W-1:0] SUM_RST = 22'h000000;
    localparam logic [CNT_W-1:0] CNT_RST = 7'h00;
    localparam logic [CNT_W-1:0] CNT_ONE = 7'h01;
    localparam logic [NUM_FLAGS-1:0] FLAGS_RST = 8'h00;

    // ****************************************
    // Marker pulse timing
    // ****************************************
    localparam int CLK_PERIOD_NS = 40;
    localparam int MARK_WIDTH_NS = 1000;
    localparam int MARK_CYC = (MARK_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int MCNT_W = 5;
    localparam logic [MCNT_W-1:0] MARK_LOAD = MCNT_W'(MARK_CYC);
    localparam logic [MCNT_W-1:0] MCNT_RST = 5'h00;
    localparam logic [MCNT_W-1:0] MCNT_ONE = 5'h01;

    // Event sequencing states.
    typedef enum logic [1:0] {SFC_COLLECT, SFC_FLAGS, SFC_DECIDE} sfc_state_t;
endpackage
`default_nettype wire

// [sfc_stream_src.sv]
// Sample source model: streams one twelve-channel event, honouring the ready handshake.
`default_nettype none
module sfc_stream_src
(
    // Clock
    input wire logic i_clk_sys,
    // Control from the bench
    input wire logic i_go,
    input wire logic [sfc_pkg::DATA_W-1:0] i_lvl0,
    input wire logic [sfc_pkg::DATA_W-1:0] i_lvl1,
    // Sample stream toward the block
    input wire logic i_ready,
    output logic o_valid,
    output logic o_last,
    output logic [sfc_pkg::CHAN_W-1:0] o_chan,
    output logic [sfc_pkg::DATA_W-1:0] o_data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic taken_r;
    logic [sfc_pkg::CHAN_W-1:0] chan_nxt;

    // Channels 0..3 carry level 0, 10..11 level 1, the rest a large value no band may use.
    function automatic logic [sfc_pkg::DATA_W-1:0] data_of(input logic [sfc_pkg::CHAN_W-1:0] c);
        if (c < 6'h04)
            return i_lvl0;
        if (c > 6'h09)
            return i_lvl1;
        return 16'hFFFF;
    endfunction

    assign chan_nxt = o_chan + 6'h01;

    // Starts idle with the lines parked.
    initial
    begin
        taken_r = 1'b0;
        o_valid = 1'b0;
        o_last = 1'b0;
        o_chan = 6'h00;
        o_data = 16'h0000;
    end

    // Notes whether the offered sample was accepted at this rising edge.
    always @(posedge i_clk_sys)
    begin
        taken_r <= o_valid && i_ready;
    end

    // Holds a refused sample, advances an accepted one, inverts lines once released.
    always @(negedge i_clk_sys)
    begin
        if (i_go)
        begin
            o_valid <= 1'b1;
            o_chan <= 6'h00;
            o_data <= data_of(6'h00);
            o_last <= 1'b0;
        end
        else if (o_valid && taken_r && o_last)
        begin
            o_valid <= 1'b0;
            o_last <= 1'b0;
            o_chan <= ~o_chan;
            o_data <= ~o_data;
        end
        else if (o_valid && taken_r)
        begin
            o_chan <= chan_nxt;
            o_data <= data_of(chan_nxt);
            o_last <= (chan_nxt == 6'h0B);
        end
    end
endmodule
`default_nettype wire

// [sfc_top.sv]
// Spectral flag comparator: band averages, eight flags, discriminator, marker and gating.
`default_nettype none
module sfc_top
(
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_resetn,
    // Sample stream, one channel per cycle
    input wire logic i_smp_valid,
    input wire logic i_smp_last,
    input wire logic [sfc_pkg::CHAN_W-1:0] i_smp_chan,
    input wire logic [sfc_pkg::DATA_W-1:0] i_smp_data,
    output logic o_smp_ready,
    // Band configuration, band b in slice b
    input wire logic [sfc_pkg::NUM_BANDS-1:0] i_band_en,
    input wire logic [sfc_pkg::NUM_BANDS*sfc_pkg::CHAN_W-1:0] i_band_lo,
    input wire logic [sfc_pkg::NUM_BANDS*sfc_pkg::CHAN_W-1:0] i_band_hi,
    // Flag configuration, flag f in slice f
    input wire logic [sfc_pkg::NUM_FLAGS-1:0] i_flag_en,
    input wire logic [sfc_pkg::NUM_FLAGS-1:0] i_lhs_is_band,
    input wire logic [sfc_pkg::NUM_FLAGS*sfc_pkg::BSEL_W-1:0] i_lhs_band,
    input wire logic [sfc_pkg::NUM_FLAGS*sfc_pkg::MULT_W-1:0] i_lhs_mult,
    input wire logic [sfc_pkg::NUM_FLAGS-1:0] i_rhs_is_band,
    input wire logic [sfc_pkg::NUM_FLAGS*sfc_pkg::BSEL_W-1:0] i_rhs_band,
    input wire logic [sfc_pkg::NUM_FLAGS*sfc_pkg::MULT_W-1:0] i_rhs_mult,
    // Discriminator and output control
    input wire logic [sfc_pkg::DISC_W-1:0] i_disc_table,
    input wire logic i_filter_en,
    input wire logic i_block_tx,
    // Results
    output logic [sfc_pkg::NUM_FLAGS-1:0] o_flags,
    output logic o_match,
    output logic o_evt_done,
    output logic o_evt_send,
    output logic o_marker
);
    // ****************************************
    // Declarations
    // ****************************************
    sfc_pkg::sfc_state_t state_r;
    sfc_pkg::sfc_state_t state_nxt;
    logic ready_r;
    logic ready_nxt;
    logic [sfc_pkg::NUM_FLAGS-1:0] flags_r;
    logic [sfc_pkg::NUM_FLAGS-1:0] flags_nxt;
    logic match_r;
    logic match_nxt;
    logic done_r;
    logic done_nxt;
    logic send_r;
    logic send_nxt;
    logic [sfc_pkg::MCNT_W-1:0] mcnt_r;
    logic [sfc_pkg::MCNT_W-1:0] mcnt_nxt;
    logic marker_r;
    logic marker_nxt;
    logic smp_take;
    logic acc_clear;
    logic disc_hit;
    logic [sfc_pkg::SUM_W-1:0] band_sum [sfc_pkg::NUM_BANDS];
    logic [sfc_pkg::CNT_W-1:0] band_cnt [sfc_pkg::NUM_BANDS];

    // Scaled operand cross-multiplied by the other side's count, so no divider is needed.
    function automatic logic [sfc_pkg::PROD_W-1:0] fn_term(
        input logic [sfc_pkg::MULT_W-1:0] mult,
        input logic [sfc_pkg::SUM_W-1:0] sum,
        input logic [sfc_pkg::CNT_W-1:0] cnt);
        fn_term = sfc_pkg::PROD_W'(mult) * sfc_pkg::PROD_W'(sum) * sfc_pkg::PROD_W'(cnt);
    endfunction

    assign smp_take = i_smp_valid && ready_r;
    assign acc_clear = (state_r == sfc_pkg::SFC_DECIDE);
    assign disc_hit = i_disc_table[flags_r];

    // ****************************************
    // Band accumulators
    // ****************************************
    for (genvar b = 0; b < sfc_pkg::NUM_BANDS; b++)
    begin : g_band
        sfc_band_acc u_band
        (
            .i_clk_sys(i_clk_sys),
            .i_resetn(i_resetn),
            .i_clear(acc_clear),
            .i_smp_take(smp_take),
            .i_smp_chan(i_smp_chan),
            .i_smp_data(i_smp_data),
            .i_band_en(i_band_en[b]),
            .i_band_lo(i_band_lo[b*sfc_pkg::CHAN_W +: sfc_pkg::CHAN_W]),
            .i_band_hi(i_band_hi[b*sfc_pkg::CHAN_W +: sfc_pkg::CHAN_W]),
            .o_sum(band_sum[b]),
            .o_cnt(band_cnt[b])
        );
    end

    // ****************************************
    // Event sequencing and flag evaluation
    // ****************************************
    // Collect samples, evaluate flags once, then decide and restart collection.
    always_comb
    begin
        logic [sfc_pkg::SUM_W-1:0] l_sum;
        logic [sfc_pkg::CNT_W-1:0] l_cnt;
        logic [sfc_pkg::SUM_W-1:0] r_sum;
        logic [sfc_pkg::CNT_W-1:0] r_cnt;
        logic [sfc_pkg::BSEL_W-1:0] l_idx;
        logic [sfc_pkg::BSEL_W-1:0] r_idx;
        l_sum = sfc_pkg::LSB_SUM;
        l_cnt = sfc_pkg::LSB_CNT;
        r_sum = sfc_pkg::LSB_SUM;
        r_cnt = sfc_pkg::LSB_CNT;
        l_idx = '0;
        r_idx = '0;
        state_nxt = state_r;
        ready_nxt = ready_r;
        flags_nxt = flags_r;
        match_nxt = match_r;
        done_nxt = 1'b0;
        send_nxt = 1'b0;
        case (state_r)
            sfc_pkg::SFC_COLLECT:
            begin
                if (smp_take && i_smp_last)
                begin
                    state_nxt = sfc_pkg::SFC_FLAGS;
                    ready_nxt = 1'b0;
                end
            end
            sfc_pkg::SFC_FLAGS:
            begin
                for (int f = 0; f < sfc_pkg::NUM_FLAGS; f++)
                begin
                    l_idx = i_lhs_band[f*sfc_pkg::BSEL_W +: sfc_pkg::BSEL_W];
                    r_idx = i_rhs_band[f*sfc_pkg::BSEL_W +: sfc_pkg::BSEL_W];
                    l_sum = i_lhs_is_band[f] ? band_sum[l_idx] : sfc_pkg::LSB_SUM;
                    l_cnt = i_lhs_is_band[f] ? band_cnt[l_idx] : sfc_pkg::LSB_CNT;
                    r_sum = i_rhs_is_band[f] ? band_sum[r_idx] : sfc_pkg::LSB_SUM;
                    r_cnt = i_rhs_is_band[f] ? band_cnt[r_idx] : sfc_pkg::LSB_CNT;
                    // Left avg > right avg  <=>  mL*sumL*cntR > mR*sumR*cntL.
                    flags_nxt[f] = i_flag_en[f] &&
                        (fn_term(i_lhs_mult[f*sfc_pkg::MULT_W +: sfc_pkg::MULT_W], l_sum, r_cnt) >
                         fn_term(i_rhs_mult[f*sfc_pkg::MULT_W +: sfc_pkg::MULT_W], r_sum, l_cnt));
                end
                state_nxt = sfc_pkg::SFC_DECIDE;
            end
            sfc_pkg::SFC_DECIDE:
            begin
                match_nxt = i_filter_en && disc_hit;
                send_nxt = !(i_filter_en && i_block_tx) || disc_hit;
                done_nxt = 1'b1;
                ready_nxt = 1'b1;
                state_nxt = sfc_pkg::SFC_COLLECT;
            end
            default:
            begin
                state_nxt = sfc_pkg::SFC_COLLECT;
                ready_nxt = 1'b1;
            end
        endcase
    end

    // Register the sequencing and result state.
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_resetn)
        begin
            state_r <= sfc_pkg::SFC_COLLECT;
            ready_r <= 1'b1;
            flags_r <= sfc_pkg::FLAGS_RST;
            match_r <= 1'b0;
            done_r <= 1'b0;
            send_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            ready_r <= ready_nxt;
            flags_r <= flags_nxt;
            match_r <= match_nxt;
            done_r <= done_nxt;
            send_r <= send_nxt;
        end
    end

    // ****************************************
    // Marker pulse
    // ****************************************
    // A new match reloads the width counter, stretching a pulse already running.
    always_comb
    begin
        mcnt_nxt = mcnt_r;
        if ((state_r == sfc_pkg::SFC_DECIDE) && i_filter_en && disc_hit)
        begin
            mcnt_nxt = sfc_pkg::MARK_LOAD;
        end
        else if (mcnt_r != sfc_pkg::MCNT_RST)
        begin
            mcnt_nxt = mcnt_r - sfc_pkg::MCNT_ONE;
        end
        marker_nxt = (mcnt_nxt != sfc_pkg::MCNT_RST);
    end

    // Register the marker counter and pin.
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_resetn)
        begin
            mcnt_r <= sfc_pkg::MCNT_RST;
            marker_r <= 1'b0;
        end
        else
        begin
            mcnt_r <= mcnt_nxt;
            marker_r <= marker_nxt;
        end
    end

    assign o_smp_ready = ready_r;
    assign o_flags = flags_r;
    assign o_match = match_r;
    assign o_evt_done = done_r;
    assign o_evt_send = send_r;
    assign o_marker = marker_r;

    // ****************************************
    // Assertions
    // ****************************************
    sequence s_evt_end;
        smp_take && i_smp_last;
    endsequence

    sequence s_eval;
        !o_smp_ready ##1 !o_smp_ready ##1 (o_smp_ready && o_evt_done);
    endsequence

    property p_eval_seq;
        @(posedge i_clk_sys) disable iff (!i_resetn) s_evt_end |=> s_eval;
    endproperty
    a_eval_seq: assert property (p_eval_seq) else $error("Event evaluation sequence broken.");

    property p_done_once;
        @(posedge i_clk_sys) disable iff (!i_resetn) o_evt_done |=> !o_evt_done;
    endproperty
    a_done_once: assert property (p_done_once) else $error("Result pulse too long.");

    property p_flag_off;
        @(posedge i_clk_sys) disable iff (!i_resetn)
            o_evt_done |-> ((o_flags & ~$past(i_flag_en, 2)) == '0);
    endproperty
    a_flag_off: assert property (p_flag_off) else $error("Disabled flag reads true.");

    property p_match_src;
        @(posedge i_clk_sys) disable iff (!i_resetn)
            o_match |-> (o_evt_done ? $past(i_filter_en) : $past(o_match));
    endproperty
    a_match_src: assert property (p_match_src) else $error("Match changed without event.");

    property p_block;
        @(posedge i_clk_sys) disable iff (!i_resetn)
            o_evt_done && !o_match && $past(i_filter_en && i_block_tx) |-> !o_evt_send;
    endproperty
    a_block: assert property (p_block) else $error("Failing event was forwarded.");

    property p_pass;
        @(posedge i_clk_sys) disable iff (!i_resetn) o_evt_done && o_match |-> o_evt_send;
    endproperty
    a_pass: assert property (p_pass) else $error("Matching event was withheld.");

    property p_marker_cause;
        @(posedge i_clk_sys) disable iff (!i_resetn) $rose(o_marker) |-> o_evt_done && o_match;
    endproperty
    a_marker_cause: assert property (p_marker_cause) else $error("Marker without match.");

    property p_marker_hold;
        @(posedge i_clk_sys) disable iff (!i_resetn) $rose(o_marker) |-> o_marker [*8];
    endproperty
    a_marker_hold: assert property (p_marker_hold) else $error("Marker pulse too short.");
endmodule
`default_nettype wire

// [spectral_flag_comparator_tb_top.sv]
// Self-checking testbench of the spectral flag comparator.
`default_nettype none
`define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin bad_count++; \
    $display("[ERR] %s expected %0h seen %0h", nm, exp, got); end end
module spectral_flag_comparator_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clk_sys = 1'b0;
    logic i_resetn = 1'b0;
    logic go = 1'b0;
    logic [15:0] lvl0 = 16'h0000;
    logic [15:0] lvl1 = 16'h0000;
    logic valid, last, ready, flt_en, blk_tx;
    logic [5:0] chan;
    logic [15:0] data;
    logic [47:0] band_lo = 48'h0;
    logic [47:0] band_hi = 48'h0;
    logic [7:0] flag_en = 8'h00, lhs_b = 8'h00, rhs_b = 8'h00, flags;
    logic [23:0] lhs_band = 24'h0, rhs_band = 24'h0;
    logic [63:0] lhs_mult = 64'h0, rhs_mult = 64'h0;
    logic [255:0] table_v = 256'h0;
    logic [7:0] band_en = 8'h03;
    logic [7:0] fmask = 8'hFF;
    logic match, done, send, marker;
    int bad_count = 0;
    int checks = 0;

    // The clock toggles every half period of 40 ns.
    always #20 i_clk_sys = ~i_clk_sys;

    sfc_stream_src src (.i_clk_sys(i_clk_sys), .i_go(go), .i_lvl0(lvl0), .i_lvl1(lvl1),
        .i_ready(ready), .o_valid(valid), .o_last(last), .o_chan(chan), .o_data(data));

    sfc_top dut (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_smp_valid(valid),
        .i_smp_last(last), .i_smp_chan(chan), .i_smp_data(data), .o_smp_ready(ready),
        .i_band_en(band_en), .i_band_lo(band_lo), .i_band_hi(band_hi), .i_flag_en(flag_en),
        .i_lhs_is_band(lhs_b), .i_lhs_band(lhs_band), .i_lhs_mult(lhs_mult),
        .i_rhs_is_band(rhs_b), .i_rhs_band(rhs_band), .i_rhs_mult(rhs_mult),
        .i_disc_table(table_v), .i_filter_en(flt_en), .i_block_tx(blk_tx), .o_flags(flags),
        .o_match(match), .o_evt_done(done), .o_evt_send(send), .o_marker(marker));

    // Sets one flag: enable, then source, band and multiplier of each side.
    task automatic cfg_flag(input int f, input logic en, input logic lb, input logic [2:0] lsel,
        input logic [7:0] lm, input logic rb, input logic [2:0] rsel, input logic [7:0] rm);
        flag_en[f] = en;
        lhs_b[f] = lb;
        lhs_band[3*f+:3] = lsel;
        lhs_mult[8*f+:8] = lm;
        rhs_b[f] = rb;
        rhs_band[3*f+:3] = rsel;
        rhs_mult[8*f+:8] = rm;
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // Streams one event with the two band levels, waits for the result and judges it.
    task automatic run_evt(input logic [15:0] l0, input logic [15:0] l1);
        int n = 0;
        logic [7:0] ef;
        logic em;
        lvl0 = l0;
        lvl1 = l1;
        go <= 1'b1;
        @(negedge i_clk_sys);
        go <= 1'b0;
        while (done !== 1'b1 && n < 100)
        begin
            @(negedge i_clk_sys);
            n++;
        end
        if (n >= 100)
        begin
            bad_count++;
            print_verdict();
        end
        ef = {5'h00, 2 * l0 > l1, 16'h0046 > l0, l0 > 16'h003C} & fmask;
        em = flt_en && table_v[ef];
        `CHK("flags", ef, flags)
        `CHK("match", em, match)
        `CHK("send", !flt_en || !blk_tx || em, send)
        `CHK("marker", em, marker)
        `CHK("ready", 1'b1, ready)
    endtask

    // Band over constant, and the marker lasts its full width.
    task automatic t_match();
        int n = 0;
        flt_en = 1'b1;
        blk_tx = 1'b0;
        run_evt(16'h0041, 16'h00C8);
        while (marker === 1'b1 && n < 100)
        begin
            n++;
            @(negedge i_clk_sys);
        end
        `CHK("marker width", sfc_pkg::MARK_CYC, n)
    endtask

    // Equal operands read false; a failing event is withheld when blocking.
    task automatic t_equal_block();
        flt_en = 1'b1;
        blk_tx = 1'b1;
        run_evt(16'h003C, 16'h0064);
        run_evt(16'h0032, 16'h0064);
    endtask

    // With the filter off there is no match and every event is sent.
    task automatic t_filter_off();
        flt_en = 1'b0;
        blk_tx = 1'b1;
        run_evt(16'h0041, 16'h0010);
    endtask

    // Filter on without blocking still sends a failing event.
    // A disabled band collects nothing, so a flag built on it reads false.
    task automatic t_noblock_band_off();
        flt_en = 1'b1;
        blk_tx = 1'b0;
        run_evt(16'h003C, 16'h0064);
        flt_en = 1'b0;
        band_en = 8'h01;
        fmask = 8'hFB;
        run_evt(16'h0041, 16'h0010);
        band_en = 8'h03;
        fmask = 8'hFF;
    endtask

    // Reset, configure, run the scenarios.
    initial
    begin
        flt_en = 1'b0;
        blk_tx = 1'b0;
        band_hi[5:0] = 6'h03;
        band_lo[11:6] = 6'h0A;
        band_hi[11:6] = 6'h0B;
        cfg_flag(0, 1'b1, 1'b1, 3'h0, 8'h01, 1'b0, 3'h0, 8'h3C);
        cfg_flag(1, 1'b1, 1'b0, 3'h0, 8'h46, 1'b1, 3'h0, 8'h01);
        cfg_flag(2, 1'b1, 1'b1, 3'h0, 8'h02, 1'b1, 3'h1, 8'h01);
        cfg_flag(3, 1'b0, 1'b1, 3'h1, 8'h01, 1'b0, 3'h0, 8'h01);
        table_v[3] = 1'b1;
        repeat (10) @(negedge i_clk_sys);
        i_resetn = 1'b1;
        @(negedge i_clk_sys);
        `CHK("ready after reset", 1'b1, ready)
        `CHK("flags after reset", 8'h00, flags)
        t_match();
        t_equal_block();
        t_filter_off();
        t_noblock_band_off();
        print_verdict();
    end
endmodule
`default_nettype wire
